// *** rtl/cmpc_top.sv ***
// Comparator control and output logic with an AXI4-Lite register slave.
//
// Functional notes
// - Pin enable clear keeps result internal; works whatever the enable bit.
// - Invert select set inverts the result for bit, pin and consumers.
// - Speed select one gives higher speed; zero gives low power.
// - Hysteresis bit drives the analog core hysteresis control line.
// - Rising and falling enables each set the event flag on that edge.
// - Positive select: 00 pin, 01 DAC, 10 fixed reference, 11 ground.
// - Negative select picks one of four shared pins; 00 is pin zero.
// - Result bit reads one when positive exceeds negative, swapped if inverted.
// - Mirror register shows both comparators' results in bits 1 and 0.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module cmpc_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // AXI4-Lite write address
  input  wire logic [3:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read address
  input  wire logic [3:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  // AXI4-Lite read data
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  // Analog core
  input  wire logic        RAW_RESULT,
  input  wire logic        OTHER_RESULT,
  output logic             CORE_ENABLE,
  output logic             SPEED_POWER_SELECT,
  output logic             HYSTERESIS_ENABLE,
  output logic [1:0]       POSITIVE_INPUT_SELECT,
  output logic [3:0]       POSITIVE_ROUTE,
  output logic [1:0]       NEGATIVE_INPUT_SELECT,
  output logic [3:0]       NEGATIVE_ROUTE,
  // Timer1 clock source, taken as synchronous
  input  wire logic        TMR_CLK,
  // Results
  output logic             COMPARATOR_RESULT,
  output logic             RESULT_PIN_ENABLE,
  output logic             RESULT_PIN,
  output logic             COMPARATOR_EVENT_FLAG,
  output logic             IRQ
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [7:0]  ctrl0;
    logic [7:0]  ctrl1;
    logic [1:0]  sts;
    logic [1:0]  msk;
    logic        aw_got;
    logic [3:0]  aw_addr;
    logic        w_got;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        pin;
  } cmpc_st_t;

  cmpc_st_t st_r;
  cmpc_st_t st_nxt;

  logic result;
  logic rise_pulse;
  logic fall_pulse;
  logic do_write;
  logic do_read;
  logic rise_ev;
  logic fall_ev;

  // One-hot routing of a 2-bit selection; used for both input multiplexers.
  function automatic logic [3:0] onehot4(input logic [1:0] sel);
    onehot4 = 4'h1 << sel;
  endfunction

  // Read-back value of a register, shared by the read path.
  function automatic logic [31:0] read_word(input logic [3:0] a, input cmpc_st_t s,
                                            input logic res, input logic other);
    logic [7:0] c0;
    c0 = s.ctrl0 & cmpc_pkg::CTRL0_WMASK;
    c0[cmpc_pkg::C0_RESULT] = res;
    case (a)
      cmpc_pkg::CTRL0_OFF:   read_word = {24'h000000, c0};
      cmpc_pkg::CTRL1_OFF:   read_word = {24'h000000, s.ctrl1};
      cmpc_pkg::MIRROR_OFF:  read_word = {30'h0, other, res};
      cmpc_pkg::IRQ_STS_OFF: read_word = {30'h0, s.sts};
      default:               read_word = 32'h00000000;
    endcase
  endfunction

  function automatic logic addr_ok(input logic [3:0] a);
    addr_ok = (a == cmpc_pkg::CTRL0_OFF) || (a == cmpc_pkg::CTRL1_OFF) ||
              (a == cmpc_pkg::MIRROR_OFF) || (a == cmpc_pkg::IRQ_STS_OFF) ||
              (a == cmpc_pkg::IRQ_MSK_OFF + 4'h0);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Result conditioning.

  cmpc_edge u_edge (
    .clk        (CLK),
    .rst_n      (RST_N),
    .invert     (st_r.ctrl0[cmpc_pkg::C0_INVERT]),
    .sync_sel   (st_r.ctrl0[cmpc_pkg::C0_SYNC]),
    .tmr_clk    (TMR_CLK),
    .raw_result (RAW_RESULT),
    .result     (result),
    .rise_pulse (rise_pulse),
    .fall_pulse (fall_pulse)
  );

  assign rise_ev = rise_pulse && st_r.ctrl1[cmpc_pkg::C1_RISE];
  assign fall_ev = fall_pulse && st_r.ctrl1[cmpc_pkg::C1_FALL];

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus and register logic.

  assign S_AXI_AWREADY = !st_r.aw_got && !st_r.bvalid;
  assign S_AXI_WREADY  = !st_r.w_got && !st_r.bvalid;
  assign S_AXI_ARREADY = !st_r.rvalid;
  assign do_read       = S_AXI_ARVALID && !st_r.rvalid;

  always_comb begin
    logic [3:0] wa;
    logic [7:0] wd;
    logic       wl;
    logic       aw_now;
    logic       w_now;
    wa       = st_r.aw_addr;
    wd       = st_r.w_data;
    wl       = st_r.w_lane0;
    aw_now   = st_r.aw_got;
    w_now    = st_r.w_got;
    do_write = 1'b0;
    st_nxt   = st_r;

    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      wa     = S_AXI_AWADDR;
      aw_now = 1'b1;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      wd    = S_AXI_WDATA[7:0];
      wl    = S_AXI_WSTRB[0];
      w_now = 1'b1;
    end
    st_nxt.aw_got  = aw_now;
    st_nxt.aw_addr = wa;
    st_nxt.w_got   = w_now;
    st_nxt.w_data  = wd;
    st_nxt.w_lane0 = wl;

    if (aw_now && w_now) begin
      do_write       = 1'b1;
      st_nxt.aw_got  = 1'b0;
      st_nxt.w_got   = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = cmpc_pkg::RESP_OKAY;
      if (wl) begin
        case (wa)
          cmpc_pkg::CTRL0_OFF: st_nxt.ctrl0 = wd & cmpc_pkg::CTRL0_WMASK;
          cmpc_pkg::CTRL1_OFF: st_nxt.ctrl1 = wd & cmpc_pkg::CTRL1_WMASK;
          cmpc_pkg::IRQ_MSK_OFF: st_nxt.msk = wd[1:0];
          cmpc_pkg::IRQ_STS_OFF: st_nxt.bresp = cmpc_pkg::RESP_OKAY;
          default: st_nxt.bresp = cmpc_pkg::RESP_SLVERR;
        endcase
      end else if (!addr_ok(wa)) begin
        st_nxt.bresp = cmpc_pkg::RESP_SLVERR;
      end
    end
    if (st_r.bvalid && S_AXI_BREADY) begin
      st_nxt.bvalid = 1'b0;
    end

    if (do_read) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = read_word(S_AXI_ARADDR, st_r, result, OTHER_RESULT);
      st_nxt.rresp  = addr_ok(S_AXI_ARADDR) ? cmpc_pkg::RESP_OKAY : cmpc_pkg::RESP_SLVERR;
      // A read of the status register clears it.
      if (S_AXI_ARADDR == cmpc_pkg::IRQ_STS_OFF) begin
        st_nxt.sts = 2'h0;
      end
    end
    if (st_r.rvalid && S_AXI_RREADY) begin
      st_nxt.rvalid = 1'b0;
    end

    // Event sets are applied after the read clear so a coincident edge is kept.
    if (rise_ev || fall_ev) begin
      st_nxt.sts[0] = 1'b1;
    end
    if (rise_pulse || fall_pulse) begin
      st_nxt.sts[1] = 1'b1;
    end

    // The pin is driven only while enabled, independent of the enable bit.
    st_nxt.pin = st_r.ctrl0[cmpc_pkg::C0_PINEN] & result;
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      st_r       <= '0;
      st_r.ctrl0 <= cmpc_pkg::CTRL0_RESET;
      st_r.ctrl1 <= cmpc_pkg::CTRL1_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP  = st_r.bresp;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA  = st_r.rdata;
  assign S_AXI_RRESP  = st_r.rresp;

  assign CORE_ENABLE           = st_r.ctrl0[cmpc_pkg::C0_ENABLE];
  assign SPEED_POWER_SELECT    = st_r.ctrl0[cmpc_pkg::C0_SPEED];
  assign HYSTERESIS_ENABLE     = st_r.ctrl0[cmpc_pkg::C0_HYST];
  assign POSITIVE_INPUT_SELECT = st_r.ctrl1[cmpc_pkg::C1_PSEL_L +: 2];
  assign POSITIVE_ROUTE        = onehot4(st_r.ctrl1[cmpc_pkg::C1_PSEL_L +: 2]);
  assign NEGATIVE_INPUT_SELECT = st_r.ctrl1[cmpc_pkg::C1_NSEL_L +: 2];
  assign NEGATIVE_ROUTE        = onehot4(st_r.ctrl1[cmpc_pkg::C1_NSEL_L +: 2]);
  assign COMPARATOR_RESULT     = result;
  assign RESULT_PIN_ENABLE     = st_r.ctrl0[cmpc_pkg::C0_PINEN];
  assign RESULT_PIN            = st_r.pin;
  assign COMPARATOR_EVENT_FLAG = st_r.sts[0];
  assign IRQ                   = |(st_r.sts & st_r.msk);

endmodule

// *** rtl/cmpc_pkg.sv ***
// Package of register offsets, field positions and reset values for the comparator control block.
package cmpc_pkg;

  // Register byte offsets on the AXI4-Lite bus.
  localparam logic [3:0] CTRL0_OFF   = 4'h0;
  localparam logic [3:0] CTRL1_OFF   = 4'h4;
  localparam logic [3:0] MIRROR_OFF  = 4'h8;
  localparam logic [3:0] IRQ_STS_OFF = 4'hc;
  localparam logic [3:0] IRQ_MSK_OFF = 4'h8;

  // Control register zero fields.
  localparam int C0_ENABLE = 7;
  localparam int C0_RESULT = 6;
  localparam int C0_PINEN  = 5;
  localparam int C0_INVERT = 4;
  localparam int C0_SPEED  = 2;
  localparam int C0_HYST   = 1;
  localparam int C0_SYNC   = 0;

  // Control register one fields.
  localparam int C1_RISE   = 7;
  localparam int C1_FALL   = 6;
  localparam int C1_PSEL_L = 4;
  localparam int C1_NSEL_L = 0;

  // Writable masks and reset values.
  localparam logic [7:0] CTRL0_WMASK = 8'hb7;
  localparam logic [7:0] CTRL1_WMASK = 8'hf3;
  localparam logic [7:0] CTRL0_RESET = 8'h04;
  localparam logic [7:0] CTRL1_RESET = 8'h00;

  // Positive input selection codes.
  localparam logic [1:0] PSEL_PIN = 2'h0;
  localparam logic [1:0] PSEL_DAC = 2'h1;
  localparam logic [1:0] PSEL_FVR = 2'h2;
  localparam logic [1:0] PSEL_GND = 2'h3;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/cmpc_edge.sv ***
// Result conditioning: polarity, optional Timer1 re-timing and edge detection.
`timescale 1ns/100ps
module cmpc_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic invert,
  input  wire logic sync_sel,
  input  wire logic tmr_clk,
  // Analog comparator decision, taken as synchronous
  input  wire logic raw_result,
  // Results
  output logic      result,
  output logic      rise_pulse,
  output logic      fall_pulse
);

  typedef struct packed {
    logic tclk;
    logic held;
    logic result;
    logic prev;
  } cmpc_edge_st_t;

  cmpc_edge_st_t st_r;
  cmpc_edge_st_t st_nxt;
  logic          pol;

  always_comb begin
    pol    = raw_result ^ invert;
    st_nxt = st_r;
    st_nxt.tclk = tmr_clk;
    // Falling edge of the Timer1 clock captures the polarised result.
    if (st_r.tclk && !tmr_clk) begin
      st_nxt.held = pol;
    end
    st_nxt.result = sync_sel ? st_nxt.held : pol;
    st_nxt.prev   = st_r.result;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign result     = st_r.result;
  assign rise_pulse = st_r.result && !st_r.prev;
  assign fall_pulse = !st_r.result && st_r.prev;

endmodule

// *** verification/cmpc_props.sv ***
// Port-level assertions for the comparator control block.
`timescale 1ns/100ps
module cmpc_props (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // Bus handshakes
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic [31:0] S_AXI_RDATA,
  // Comparator side
  input wire logic        COMPARATOR_RESULT,
  input wire logic        RESULT_PIN_ENABLE,
  input wire logic        RESULT_PIN,
  input wire logic [1:0]  POSITIVE_INPUT_SELECT,
  input wire logic [3:0]  POSITIVE_ROUTE,
  input wire logic [1:0]  NEGATIVE_INPUT_SELECT,
  input wire logic [3:0]  NEGATIVE_ROUTE,
  input wire logic        COMPARATOR_EVENT_FLAG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  pin_gate_a: assert property (!RESULT_PIN_ENABLE |=> !RESULT_PIN)
    else $error("pin driven while disabled");
  pos_route_a: assert property (POSITIVE_ROUTE == (4'h1 << POSITIVE_INPUT_SELECT))
    else $error("positive route mismatch");
  neg_route_a: assert property (NEGATIVE_ROUTE == (4'h1 << NEGATIVE_INPUT_SELECT))
    else $error("negative route mismatch");
  flag_cause_a: assert property ($rose(COMPARATOR_EVENT_FLAG) |->
    ($past(COMPARATOR_RESULT, 1) != $past(COMPARATOR_RESULT, 2)) ||
    ($past(COMPARATOR_RESULT, 2) != $past(COMPARATOR_RESULT, 3)))
    else $error("flag set without result edge");
  upper_zero_a: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:8] == 24'h0)
    else $error("upper read bits not zero");
  wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID &&
    S_AXI_WREADY |=> S_AXI_BVALID) else $error("write not answered");
  rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  ar_block_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while answer pending");
  aw_block_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("write taken while answer pending");
endmodule

// *** verification/cmpc_core_model.sv ***
// Behavioural analog comparator core and Timer1 clock source.
`timescale 1ns/100ps
module cmpc_core_model (
  // Clock and stimulus
  input  wire logic       clk,
  input  wire logic       vp_gt_vn,
  input  wire logic       other_in,
  input  wire logic       tmr_run,
  // Routing from the block
  input  wire logic [3:0] pos_route,
  // Decisions and Timer1 clock
  output logic            raw_result,
  output logic            other_result,
  output logic            tmr_clk
);
  logic [1:0] div_r = 2'h0;
  initial {raw_result, other_result, tmr_clk} = 3'b001;
  // Ground on the positive input can never exceed the negative one.
  always @(posedge clk) begin
    raw_result <= pos_route[3] ? 1'b0 : vp_gt_vn;
    other_result <= other_in;
    div_r <= div_r + 2'h1;
    tmr_clk <= tmr_run ? div_r[1] : 1'b1;
  end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the comparator control block.
`timescale 1ns/100ps
module tb;
  logic        CLK, RST_N, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID;
  logic        S_AXI_RREADY, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
  logic        S_AXI_RVALID, RAW_RESULT, OTHER_RESULT, CORE_ENABLE, SPEED_POWER_SELECT;
  logic        HYSTERESIS_ENABLE, TMR_CLK, COMPARATOR_RESULT, RESULT_PIN_ENABLE;
  logic        RESULT_PIN, COMPARATOR_EVENT_FLAG, IRQ, lvl, oth, trun;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, POSITIVE_INPUT_SELECT, NEGATIVE_INPUT_SELECT, r;
  logic [3:0]  S_AXI_AWADDR, S_AXI_WSTRB, S_AXI_ARADDR, POSITIVE_ROUTE, NEGATIVE_ROUTE;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  int          err_total = 0, n_checks = 0, cyc = 0;

  always #4 CLK = ~CLK;

  cmpc_top DUT (.CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA,
    .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY,
    .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID,
    .S_AXI_RREADY, .RAW_RESULT, .OTHER_RESULT, .CORE_ENABLE, .SPEED_POWER_SELECT,
    .HYSTERESIS_ENABLE, .POSITIVE_INPUT_SELECT, .POSITIVE_ROUTE, .NEGATIVE_INPUT_SELECT,
    .NEGATIVE_ROUTE, .TMR_CLK, .COMPARATOR_RESULT, .RESULT_PIN_ENABLE, .RESULT_PIN,
    .COMPARATOR_EVENT_FLAG, .IRQ);
  cmpc_core_model u_core (.clk(CLK), .vp_gt_vn(lvl), .other_in(oth), .tmr_run(trun),
    .pos_route(POSITIVE_ROUTE), .raw_result(RAW_RESULT), .other_result(OTHER_RESULT),
    .tmr_clk(TMR_CLK));

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic results();
    if (err_total == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Handshakes are judged at the rising edge, where the slave samples them too.
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic b;
    b = 1'b0;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= {24'h0, v};
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    while (!b) begin
      @(posedge CLK);
      b = S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WVALID && S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
    end
    S_AXI_BREADY <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [3:0] a);
    logic rv;
    rv = 1'b0;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    while (!rv) begin
      @(posedge CLK);
      rv = S_AXI_RVALID;
      if (rv) {r, d} = {S_AXI_RRESP, S_AXI_RDATA};
      if (S_AXI_ARVALID && S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
    end
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_ctrl();
    rd(cmpc_pkg::CTRL0_OFF);
    chk({SPEED_POWER_SELECT, d}, {1'b1, 32'h04});
    wr(cmpc_pkg::CTRL0_OFF, 8'hb6);
    tick(4);
    chk({COMPARATOR_RESULT, RESULT_PIN, HYSTERESIS_ENABLE}, 3'b111);
    rd(cmpc_pkg::CTRL0_OFF);
    chk(d, 32'hf6);
    wr(cmpc_pkg::CTRL0_OFF, 8'h10);
    tick(4);
    chk({RESULT_PIN, COMPARATOR_RESULT, SPEED_POWER_SELECT}, 3'b010);
    lvl <= 1'b1;
    wr(cmpc_pkg::CTRL0_OFF, 8'h20);
    tick(4);
    chk({RESULT_PIN, COMPARATOR_RESULT, CORE_ENABLE}, 3'b110);
    lvl <= 1'b0;
  endtask
  task automatic t_sel();
    for (int i = 0; i < 4; i++) begin
      wr(cmpc_pkg::CTRL1_OFF, {2'h0, i[1:0], 2'h0, i[1:0]});
      tick(2);
      chk({POSITIVE_ROUTE, NEGATIVE_ROUTE}, {4'h1 << i, 4'h1 << i});
      rd(cmpc_pkg::CTRL1_OFF);
      chk(d, {26'h0, i[1:0], 2'h0, i[1:0]});
    end
  endtask
  task automatic t_flag();
    wr(cmpc_pkg::CTRL1_OFF, 8'h80);
    wr(cmpc_pkg::IRQ_MSK_OFF, 8'h01);
    wr(cmpc_pkg::CTRL0_OFF, 8'h00);
    rd(cmpc_pkg::IRQ_STS_OFF);
    lvl <= 1'b1;
    tick(4);
    chk({COMPARATOR_EVENT_FLAG, IRQ}, 2'b11);
    rd(cmpc_pkg::IRQ_STS_OFF);
    chk(d[0], 1'b1);
    lvl <= 1'b0;
    tick(4);
    chk({COMPARATOR_EVENT_FLAG, IRQ}, 2'b00);
    wr(cmpc_pkg::CTRL1_OFF, 8'h40);
    lvl <= 1'b1;
    tick(4);
    chk(COMPARATOR_EVENT_FLAG, 1'b0);
    lvl <= 1'b0;
    tick(4);
    chk(COMPARATOR_EVENT_FLAG, 1'b1);
    wr(cmpc_pkg::IRQ_MSK_OFF, 8'h00);
    chk(IRQ, 1'b0);
    rd(cmpc_pkg::IRQ_STS_OFF);
  endtask
  task automatic t_sync();
    wr(cmpc_pkg::CTRL0_OFF, 8'h01);
    lvl <= 1'b1;
    tick(8);
    chk(COMPARATOR_RESULT, 1'b0);
    trun <= 1'b1;
    tick(8);
    chk(COMPARATOR_RESULT, 1'b1);
    trun <= 1'b0;
    lvl <= 1'b0;
    oth <= 1'b1;
    wr(cmpc_pkg::CTRL0_OFF, 8'h00);
    tick(4);
    rd(cmpc_pkg::MIRROR_OFF);
    chk({r, d}, {cmpc_pkg::RESP_OKAY, 32'h2});
    rd(4'h2);
    chk({r, d}, {cmpc_pkg::RESP_SLVERR, 32'h0});
  endtask

  always @(posedge CLK) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      results();
    end
  end
  initial begin
    {CLK, RST_N, lvl, oth, trun} = 5'h0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 40'h0;
    S_AXI_WSTRB = 4'hf;
    tick(4);
    RST_N <= 1'b1;
    tick(1);
    t_ctrl();
    t_sel();
    t_flag();
    t_sync();
    results();
  end
endmodule

bind cmpc_top cmpc_props u_props (.CLK, .RST_N, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID, .S_AXI_RDATA, .COMPARATOR_RESULT, .RESULT_PIN_ENABLE, .RESULT_PIN,
  .POSITIVE_INPUT_SELECT, .POSITIVE_ROUTE, .NEGATIVE_INPUT_SELECT, .NEGATIVE_ROUTE,
  .COMPARATOR_EVENT_FLAG);
